// file: core/sgo_defines.svh
// register offsets, field positions, reset values and codes of the sync gate config bank
// assumes an 8-bit register data path with 12-bit register addresses
`ifndef SGO_DEFINES_SVH
`define SGO_DEFINES_SVH

`define SGO_ADDR_W          12
`define SGO_OFS_GLOBAL_GATE 12'h160
`define SGO_OFS_BLOCK_GATES 12'h161
`define SGO_OFS_OUT_CONFIG  12'h162
`define SGO_OFS_SRC_SELECT  12'h163

`define SGO_RST_GLOBAL_GATE 8'h00
`define SGO_RST_BLOCK_GATES 8'h00
`define SGO_RST_OUT_CONFIG  8'h00
`define SGO_RST_SRC_SELECT  8'h00

`define SGO_BIT_SERIAL_GATE 6
`define SGO_BIT_DOWNC_GATE  4
`define SGO_BIT_OSC_GATE    2
`define SGO_BIT_TIMER_GATE  0
`define SGO_BIT_STAMP       6
`define SGO_BIT_GAIN        3
`define SGO_BIT_COMPLEX     2
`define SGO_BIT_WIDTH       1
`define SGO_BIT_CODING      0

`define SGO_STAMP_ON        2'h3
`define SGO_GAIN_FORCE_6DB  2'h3
`define SGO_GAIN_FORCE_UNIT 2'h2
`define SGO_OUT_CFG_MASK    8'hdf
`define SGO_GLOBAL_MASK     8'h03

`endif

// file: core/sgo_pkg.sv
// types shared by the sync gate config bank
// assumes the defines header for numeric values
package sgo_pkg;
  typedef enum logic [1:0] {
    SGO_GATE_PASS_ALL   = 2'b00,
    SGO_GATE_PASS_FIRST = 2'b01,
    SGO_GATE_BLOCK_ALL  = 2'b10,
    SGO_GATE_ISSUE      = 2'b11
  } sgo_gate_mode_t;

  typedef enum logic [1:0] {
    SGO_SRC_OWN   = 2'b00,
    SGO_SRC_OTHER = 2'b01,
    SGO_SRC_SUM   = 2'b10,
    SGO_SRC_DIFF  = 2'b11
  } sgo_src_t;
endpackage

// file: core/sgo_gate.sv
// one sync pulse gate: pass all, pass first, block all, issue on entry to 11
// assumes sync_in is a clk-synchronous one-cycle pulse and wr_pulse marks a field write
`timescale 1ns/1ps
module sgo_gate (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic [1:0] mode,
  input  wire logic       wr_pulse,
  input  wire logic       issue,
  // pulses
  input  wire logic       sync_in,
  output logic            sync_out
);
  logic passed_ff;
  logic nxt_passed;
  logic pass_now;

  // gate decode from mode code
  assign pass_now = (mode == sgo_pkg::SGO_GATE_PASS_ALL) ||
                    ((mode == sgo_pkg::SGO_GATE_PASS_FIRST) && !passed_ff);
  // rewrite forgets the passed pulse; a pulse in the write cycle does not count
  assign nxt_passed = wr_pulse ? 1'b0 : (passed_ff | (sync_in & pass_now));

  // record of a passed first pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      passed_ff <= 1'b0;
    end else begin
      passed_ff <= nxt_passed;
    end
  end

  // registered gated pulse, or internal pulse on entry to 11
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= (sync_in & pass_now) | issue;
    end
  end
endmodule

// file: core/sgo_config.sv
// sync gate, stamp, gain and output configuration bank of the converter back end
// assumes a byte-wide register port (addr, wdata, wr_en, rd_en, rdata) synchronous to clk
// assumes sync_in already sits in the clk domain as a one-cycle high pulse
// assumes the filters, oscillator and serializer read the decoded levels and gated pulses directly
// assumes reset is held for at least one clk edge; every register clears to zero
`timescale 1ns/1ps
`include "sgo_defines.svh"
module sgo_config #(
  parameter int SAMPLE_W = 16
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // register port
  input  wire logic [`SGO_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr_en,
  input  wire logic                   reg_rd_en,
  output logic      [7:0]             reg_rdata,
  // sync input and gated outputs
  input  wire logic                   sync_in,
  output logic                        global_sync,
  output logic                        serial_out_sync,
  output logic                        downconv_sync,
  output logic                        oscillator_sync,
  output logic                        osc_timer_sync,
  // sample stamping
  input  wire logic                   overrange_on_lsb,
  input  wire logic                   overrange,
  input  wire logic [SAMPLE_W-1:0]    sample_in,
  output logic      [SAMPLE_W-1:0]    sample_out,
  // channel samples into the downconverter sources
  input  wire logic [SAMPLE_W-1:0]    chan_a,
  input  wire logic [SAMPLE_W-1:0]    chan_b,
  output logic      [4*SAMPLE_W-1:0]  downconv_src,
  // decoded configuration
  output logic                        gain_6db,
  output logic                        complex_decim_enable,
  output logic                        output_width_select,
  output logic                        offset_binary
);
  logic [7:0] global_gate_ff;
  logic [7:0] block_gates_ff;
  logic [7:0] out_config_ff;
  logic [7:0] src_select_ff;

  // address decode; a write lands at the edge that sees wr_en, so fields change one cycle later
  // and the gates below see the new code from that cycle on
  logic wr_global;
  logic wr_blocks;
  logic wr_config;
  logic wr_select;
  assign wr_global = reg_wr_en && (reg_addr == `SGO_OFS_GLOBAL_GATE);
  assign wr_blocks = reg_wr_en && (reg_addr == `SGO_OFS_BLOCK_GATES);
  assign wr_config = reg_wr_en && (reg_addr == `SGO_OFS_OUT_CONFIG);
  assign wr_select = reg_wr_en && (reg_addr == `SGO_OFS_SRC_SELECT);

  // register storage; reserved bits are not stored and read zero
  // masking here keeps a stray host write from reaching the gate decode or the lsb path
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      global_gate_ff <= `SGO_RST_GLOBAL_GATE;
      block_gates_ff <= `SGO_RST_BLOCK_GATES;
      out_config_ff  <= `SGO_RST_OUT_CONFIG;
      src_select_ff  <= `SGO_RST_SRC_SELECT;
    end else begin
      if (wr_global) global_gate_ff <= reg_wdata & `SGO_GLOBAL_MASK;
      if (wr_blocks) block_gates_ff <= reg_wdata;
      if (wr_config) out_config_ff <= reg_wdata & `SGO_OUT_CFG_MASK;
      if (wr_select) src_select_ff <= reg_wdata;
    end
  end

  // read mux, unmapped addresses read zero
  // read data is registered and holds between reads, so a slow host may sample it late
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        `SGO_OFS_GLOBAL_GATE: reg_rdata <= global_gate_ff;
        `SGO_OFS_BLOCK_GATES: reg_rdata <= block_gates_ff;
        `SGO_OFS_OUT_CONFIG:  reg_rdata <= out_config_ff;
        `SGO_OFS_SRC_SELECT:  reg_rdata <= src_select_ff;
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // five gates: global, then per-block fields from bit 6 down
  // vector order: [4] global, [3] serial lane, [2] downconverter, [1] oscillator, [0] timer
  // each gate keeps its own pass-first record, but a block register write re-arms all four block gates; only the global gate re-arms alone
  logic [4:0] gate_sync;
  logic [9:0] gate_fields;
  logic [9:0] fields_ff;
  logic [4:0] gate_wr;
  assign gate_fields = {global_gate_ff[1:0], block_gates_ff};
  // a block register write re-arms all four block gates, even a field that keeps its code
  assign gate_wr     = {wr_global, {4{wr_blocks}}};

  // previous field values to catch entry into 11
  // only a change into 11 issues; rewriting 11 over 11 stays quiet
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fields_ff <= 10'h000;
    end else begin
      fields_ff <= gate_fields;
    end
  end

  // shared loop variable of both generate loops
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_gate
      // held for one cycle, then dropped even while the field stays at 11
      logic issue;
      // one internal pulse when the field newly becomes 11
      assign issue = (gate_fields[2*gi+1:2*gi] == sgo_pkg::SGO_GATE_ISSUE) &&
                     (fields_ff[2*gi+1:2*gi] != sgo_pkg::SGO_GATE_ISSUE);
      // the gate sees the old code during the write cycle and the new one from the next
      sgo_gate u_gate (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .mode     (gate_fields[2*gi+1:2*gi]),
        .wr_pulse (gate_wr[gi]),
        .issue    (issue),
        .sync_in  (sync_in),
        .sync_out (gate_sync[gi])
      );
    end
  endgenerate

  // gated pulses per block
  // the global gate also governs the test pattern path fed from global_sync
  // each output is a registered one-cycle pulse, one clk after the input pulse, or one clk after its field enters 11
  assign global_sync     = gate_sync[4];
  assign serial_out_sync = gate_sync[`SGO_BIT_SERIAL_GATE/2];
  assign downconv_sync   = gate_sync[`SGO_BIT_DOWNC_GATE/2];
  assign oscillator_sync = gate_sync[`SGO_BIT_OSC_GATE/2];
  assign osc_timer_sync  = gate_sync[`SGO_BIT_TIMER_GATE/2];

  // output configuration decode
  logic [1:0] stamp_sel;
  logic [1:0] gain_sel;
  logic       gain_force_on;
  logic       gain_force_off;
  assign stamp_sel            = out_config_ff[`SGO_BIT_STAMP+1:`SGO_BIT_STAMP];
  assign gain_sel             = out_config_ff[`SGO_BIT_GAIN+1:`SGO_BIT_GAIN];
  assign complex_decim_enable = out_config_ff[`SGO_BIT_COMPLEX];
  assign output_width_select  = out_config_ff[`SGO_BIT_WIDTH];
  assign offset_binary        = out_config_ff[`SGO_BIT_CODING];
  // codes 0x3 and 0x2 override the mode; 00 and 01 leave the 6dB step to complex decimation
  assign gain_force_on  = (gain_sel == `SGO_GAIN_FORCE_6DB);
  assign gain_force_off = (gain_sel == `SGO_GAIN_FORCE_UNIT);
  assign gain_6db       = gain_force_on | (~gain_force_off & complex_decim_enable);

  // sample lsb replacement and coding
  // offset binary only flips the sign bit; the lsb choice is made after coding
  logic [SAMPLE_W-1:0] coded;
  logic                lsb;
  assign coded = offset_binary ? {~sample_in[SAMPLE_W-1], sample_in[SAMPLE_W-2:0]} : sample_in;
  assign lsb   = overrange_on_lsb ? overrange :
                 (stamp_sel == `SGO_STAMP_ON) ? sync_in : coded[0];

  // sample register, one cycle of latency like the rest of the data path
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_out <= '0;
    end else begin
      sample_out <= {coded[SAMPLE_W-1:1], lsb};
    end
  end

  // downconverter source muxes, odd ones swap own/other channel
  // one bit of sign extension keeps the sum and difference from wrapping before the halving
  // halving is an arithmetic shift, so an odd sum rounds toward minus infinity
  logic [SAMPLE_W:0] half_sum;
  logic [SAMPLE_W:0] half_dif;
  assign half_sum = {chan_a[SAMPLE_W-1], chan_a} + {chan_b[SAMPLE_W-1], chan_b};
  assign half_dif = {chan_a[SAMPLE_W-1], chan_a} - {chan_b[SAMPLE_W-1], chan_b};

  generate
    for (gi = 0; gi < 4; gi++) begin : g_src
      logic [1:0]          sel;
      logic [SAMPLE_W-1:0] first;
      logic [SAMPLE_W-1:0] second;
      logic [SAMPLE_W-1:0] pick;
      localparam bit SWAP = (gi % 2 == 1); // odd downconverters take channel b as their own
      assign sel    = src_select_ff[2*gi+1:2*gi];
      assign first  = SWAP ? chan_b : chan_a;
      assign second = SWAP ? chan_a : chan_b;
      assign pick   = (sel == sgo_pkg::SGO_SRC_OWN)   ? first :
                      (sel == sgo_pkg::SGO_SRC_OTHER) ? second :
                      (sel == sgo_pkg::SGO_SRC_SUM)   ? half_sum[SAMPLE_W:1] :
                                                        half_dif[SAMPLE_W:1];
      // source register of this downconverter's slice
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          downconv_src[gi*SAMPLE_W +: SAMPLE_W] <= '0;
        end else begin
          downconv_src[gi*SAMPLE_W +: SAMPLE_W] <= pick;
        end
      end
    end
  endgenerate
endmodule

// file: sim/sgo_config_checker.sv
// assertions on the sync gate config bank, watching its ports only
// assumes register writes take effect at the write edge, as in the bank
`timescale 1ns/1ps
`include "sgo_defines.svh"
module sgo_config_checker #(
  parameter int SAMPLE_W = 16
) (
  // clock, reset and register writes
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire logic [`SGO_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr_en,
  // sync, stamping and gain
  input wire logic                   sync_in,
  input wire logic                   global_sync,
  input wire logic                   serial_out_sync,
  input wire logic                   osc_timer_sync,
  input wire logic                   overrange_on_lsb,
  input wire logic                   overrange,
  input wire logic [SAMPLE_W-1:0]    sample_out,
  input wire logic                   gain_6db
);
  logic [7:0] g_ff;
  logic [7:0] b_ff;
  logic [7:0] o_ff;
  // shadow copies of the gate and output config registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      g_ff <= 8'h00;
      b_ff <= 8'h00;
      o_ff <= 8'h00;
    end else if (reg_wr_en) begin
      if (reg_addr == `SGO_OFS_GLOBAL_GATE) g_ff <= reg_wdata;
      if (reg_addr == `SGO_OFS_BLOCK_GATES) b_ff <= reg_wdata;
      if (reg_addr == `SGO_OFS_OUT_CONFIG) o_ff <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // gate behaviour
  a_global_pass: assert property (sync_in && g_ff[1:0] == 2'h0 && !reg_wr_en |=> global_sync)
    else $error("global gate dropped a pulse");
  a_global_block: assert property ((g_ff[1:0] == 2'h2)[*4] |=> !global_sync)
    else $error("global gate leaked a pulse");
  a_issue_pulse: assert property (g_ff[1:0] == 2'h3 && $past(g_ff[1:0]) != 2'h3 |-> ##[0:3] global_sync)
    else $error("no pulse issued on entry to 11");
  a_serial_pass: assert property (sync_in && g_ff[1:0] == 2'h0 && b_ff[7:6] == 2'h0 && !reg_wr_en
    |=> serial_out_sync)
    else $error("serial gate dropped a pulse");
  a_timer_block: assert property ((b_ff[1:0] == 2'h2)[*4] |=> !osc_timer_sync)
    else $error("timer gate leaked a pulse");
  // lsb stamping and gain decode
  a_stamp_lsb: assert property (o_ff[7:6] == 2'h3 && !overrange_on_lsb && !reg_wr_en
    |=> sample_out[0] == $past(sync_in))
    else $error("sync not stamped on lsb");
  a_ovr_wins: assert property (overrange_on_lsb |=> sample_out[0] == $past(overrange))
    else $error("overrange not on lsb");
  a_gain_decode: assert property (o_ff[4:3] != 2'h1
    |-> gain_6db == (o_ff[4:3] == 2'h3 || (o_ff[4:3] != 2'h2 && o_ff[2])))
    else $error("gain decode wrong");
  // main scenarios reached
  c_first_mode: cover property (g_ff[1:0] == 2'h1 && sync_in);
  c_serial_issue: cover property (b_ff[7:6] == 2'h3);
  c_stamp: cover property (o_ff[7:6] == 2'h3 && sync_in);
endmodule
bind sgo_config sgo_config_checker #(.SAMPLE_W(SAMPLE_W)) i_sgo_config_checker (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
  .sync_in(sync_in), .global_sync(global_sync), .serial_out_sync(serial_out_sync),
  .osc_timer_sync(osc_timer_sync), .overrange_on_lsb(overrange_on_lsb), .overrange(overrange),
  .sample_out(sample_out), .gain_6db(gain_6db));

// file: sim/sgo_sync_src.sv
// external sync timing source: one-cycle high pulse per request
// assumes req is set by non-blocking assignment at a falling edge
`timescale 1ns/1ps
module sgo_sync_src (
  // clock
  input  wire logic clk,
  // request and pulse
  input  wire logic req,
  output logic      sync_pulse
);
  // pulse follows the request one falling edge later and lasts one cycle; settles at the first falling edge
  always @(negedge clk) sync_pulse <= req;
endmodule

// file: sim/sgo_config_tb.sv
// self-checking bench of the sync gate config bank
// assumes the bank and the sync source model, one 125 MHz clock
`timescale 1ns/1ps
`include "sgo_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t: %h vs %h", $time, a, b); end end
module sgo_config_tb;
  localparam int W = 16;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, req = 1'b0, ol = 1'b0, ov = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, oc, ss;
  logic [W-1:0] smp = '0, ca = '0, cb = '0;
  logic [W:0] sm, df;
  wire [7:0] reg_rdata;
  wire [4:0] so;
  wire [W-1:0] sample_out;
  wire [4*W-1:0] src;
  wire sync_in, gain, cplx, width, ofs;
  int errors = 0, num_checks = 0, cycles = 0, cnt[5] = '{0, 0, 0, 0, 0}, base;
  integer seed = 32'he7dc05db;
  sgo_sync_src i_sgo_sync_src (.clk(clk), .req(req), .sync_pulse(sync_in));
  sgo_config #(.SAMPLE_W(W)) i_sgo_config (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .sync_in(sync_in), .global_sync(so[4]), .serial_out_sync(so[3]), .downconv_sync(so[2]),
    .oscillator_sync(so[1]), .osc_timer_sync(so[0]), .overrange_on_lsb(ol), .overrange(ov),
    .sample_in(smp), .sample_out(sample_out), .chan_a(ca), .chan_b(cb), .downconv_src(src),
    .gain_6db(gain), .complex_decim_enable(cplx), .output_width_select(width), .offset_binary(ofs));
  // clock, pulse counters and watchdog
  always #4 clk = ~clk;
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) if (so[i] === 1'b1) cnt[i]++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(negedge clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(negedge clk);
    reg_rd_en <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK(reg_rdata, e)
  endtask
  task automatic fire(input int n);
    repeat (n) begin
      @(negedge clk);
      req <= 1'b1;
      @(negedge clk);
      req <= 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
  // gate 4 is the global field, gates 0..3 sit two bits apart in the block register
  task automatic setg(input int k, input logic [1:0] m);
    if (k == 4) wr(`SGO_OFS_GLOBAL_GATE, {6'h00, m}); // host keeps reserved bits zero
    else wr(`SGO_OFS_BLOCK_GATES, 8'(m) << (2 * k));
  endtask
  function automatic logic [4*W-1:0] exp_src(input logic [7:0] sel);
    logic [1:0] c;
    sm = {ca[W-1], ca} + {cb[W-1], cb};
    df = {ca[W-1], ca} - {cb[W-1], cb};
    for (int i = 0; i < 4; i++) begin
      c = sel[2*i +: 2] ^ {1'b0, i[0] & ~sel[2*i+1]};
      exp_src[i*W +: W] = c == 2'h0 ? ca : c == 2'h1 ? cb : c == 2'h2 ? sm[W:1] : df[W:1];
    end
  endfunction
  // decoded levels: 0x3 forces 6dB, 0x2 forces unity, 0x0 gives 6dB only in complex decimation; 0x1 is never written, so it is modelled as no 6dB
  function automatic logic [3:0] exp_cfg(input logic [7:0] c);
    exp_cfg = {c[4:3] == 2'h3 || (c[4:3] == 2'h0 && c[2]), c[2:0]};
  endfunction
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    sys_rst <= 1'b0;
    wr(12'h164, 8'hff);
    for (int a = 0; a < 5; a++) rd(`SGO_OFS_GLOBAL_GATE + a[11:0], 8'h00); // reset values, unmapped reads 0
    for (int k = 0; k < 5; k++) begin
      for (int m = 0; m < 3; m++) begin
        base = cnt[k];
        setg(k, m[1:0]);
        fire(2);
        setg(k, m[1:0]);
        fire(1);
        `CHK(cnt[k] - base, m == 0 ? 3 : m == 1 ? 2 : 0)
      end
      base = cnt[k];
      setg(k, 2'h3);
      fire(1);
      `CHK(cnt[k] - base, 1)
    end
    wr(`SGO_OFS_BLOCK_GATES, 8'h9c);
    rd(`SGO_OFS_BLOCK_GATES, 8'h9c);
    wr(`SGO_OFS_GLOBAL_GATE, 8'h00);
    for (int n = 0; n < 24; n++) begin
      oc = n == 0 ? 8'hdf : 8'($random(seed)) & `SGO_OUT_CFG_MASK; // bit 5 kept clear
      if (oc[4:3] == 2'h1) oc[4:3] = 2'h0;
      ss = 8'($random(seed));
      wr(`SGO_OFS_OUT_CONFIG, oc);
      wr(`SGO_OFS_SRC_SELECT, ss);
      rd(`SGO_OFS_SRC_SELECT, ss);
      req <= 1'($random(seed));
      @(negedge clk);
      req <= 1'b0;
      smp <= W'($random(seed));
      ca <= W'($random(seed));
      cb <= W'($random(seed));
      ol <= n > 2 && $random(seed);
      ov <= 1'($random(seed));
      @(posedge clk);
      base = sync_in;
      @(negedge clk);
      `CHK(sample_out, {smp[W-1] ^ oc[0], smp[W-2:1], ol ? ov : oc[7:6] == 2'h3 ? base[0] : smp[0]})
      `CHK(src, exp_src(ss))
      `CHK({gain, cplx, width, ofs}, exp_cfg(oc))
    end
    wrap_up();
  end
endmodule
